// ==== verilog/opmc_top.sv ====
// Purpose: Crystal oscillator control, fast/slow switch and power-down modes
// Assumes: Oscillators are modelled by stabilisation counters; clocks as enables
// Notes: Registers over AHB-Lite, zero wait states, response always OKAY
`timescale 1ns/1ps
`default_nettype none

module opmc_top #(
    parameter int HS_STABLE_CYC = opmc_pkg::HS_STABLE_CYC,
    parameter int LS_FAST_CYC = opmc_pkg::LS_FAST_CYC,
    parameter int LS_SLOW_CYC = opmc_pkg::LS_SLOW_CYC,
    parameter int RC_STABLE_CYC = opmc_pkg::RC_STABLE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU and watchdog side
    input wire logic halt_exec,
    input wire logic wake_req,
    input wire logic wdt_enabled,
    input wire logic wdt_clear_instr,
    input wire logic crystal_pins_sel,
    output logic wdt_counter_clear,
    output logic wdt_run,
    output logic power_down_flag,
    output logic watchdog_timeout_flag,
    input wire logic wdt_timeout_evt,
    // Oscillator controls and clock enables
    output logic hs_crystal_osc_en,
    output logic hs_crystal_range_sel,
    output logic ls_crystal_osc_en,
    output logic ls_crystal_speedup,
    output logic hs_clk_run,
    output logic sub_clk_run,
    output logic sys_clk_run,
    output logic sys_on_sub,
    output logic [2:0] sys_div_sel,
    output logic cpu_hold
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    localparam int CNT_W_L = opmc_pkg::CNT_W;
    logic [7:0] scc_r;
    logic [2:0] hs_ctrl_r;
    logic [2:0] ls_ctrl_r;
    logic [CNT_W_L-1:0] hs_cnt_r;
    logic [CNT_W_L-1:0] ls_cnt_r;
    logic [CNT_W_L-1:0] rc_cnt_r;
    logic on_sub_r;
    logic [2:0] div_r;
    logic gap_r;
    logic pdf_r;
    logic to_r;
    logic pins_s1_r;
    logic pins_s2_r;
    logic halt_s1_r;
    logic halt_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;
    opmc_pkg::opmc_mode_e mode_r;
    opmc_pkg::opmc_mode_e mode_nxt;

    // ------------------------------------------------------------
    // AHB-Lite address phase capture
    // ------------------------------------------------------------
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic acc_ok;
    logic rd_now;

    // Only NONSEQ/SEQ transfers are taken, of any size
    assign acc_ok = hsel && hready && htrans[1];
    assign rd_now = acc_ok && !hwrite;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Write address is held for the data phase
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= acc_ok && hwrite;
            wr_addr_r <= haddr;
        end
    end

    logic wr_scc;
    logic wr_hs;
    logic wr_ls;
    assign wr_scc = wr_pend_r && (wr_addr_r == opmc_pkg::OFS_SYS_CLK_CTRL);
    assign wr_hs = wr_pend_r && (wr_addr_r == opmc_pkg::OFS_HS_XTAL_CTRL);
    assign wr_ls = wr_pend_r && (wr_addr_r == opmc_pkg::OFS_LS_XTAL_CTRL);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins_s1_r <= 1'b0;
            pins_s2_r <= 1'b0;
            halt_s1_r <= 1'b0;
            halt_s2_r <= 1'b0;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end
        else
        begin
            pins_s1_r <= crystal_pins_sel;
            pins_s2_r <= pins_s1_r;
            halt_s1_r <= halt_exec;
            halt_s2_r <= halt_s1_r;
            wake_s1_r <= wake_req;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic hs_stable;
    logic ls_stable;
    logic rc_stable;
    logic lxt_is_sys;
    assign hs_stable = hs_ctrl_r[opmc_pkg::XT_EN] && (hs_cnt_r == '0);
    assign ls_stable = ls_ctrl_r[opmc_pkg::XT_EN] && (ls_cnt_r == '0);
    assign rc_stable = (rc_cnt_r == '0);
    assign lxt_is_sys = on_sub_r && scc_r[opmc_pkg::SCC_LF_SRC];

    // Registers hold through power-down; only bus writes change them
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            scc_r <= opmc_pkg::SCC_RESET;
        else if (wr_scc)
            scc_r <= hwdata[7:0] & 8'hef;
    end

    // High-speed crystal: range locked while pins used and enabled
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hs_ctrl_r <= opmc_pkg::XT_RESET;
        else if (wr_hs)
        begin
            hs_ctrl_r[opmc_pkg::XT_EN] <= hwdata[opmc_pkg::XT_EN];
            if (!(pins_s2_r && hs_ctrl_r[opmc_pkg::XT_EN]))
                hs_ctrl_r[opmc_pkg::XT_MODE] <= hwdata[opmc_pkg::XT_MODE];
        end
    end

    // Low-speed crystal: speed-up frozen while it clocks the system
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ls_ctrl_r <= opmc_pkg::XT_RESET;
        else if (wr_ls)
        begin
            ls_ctrl_r[opmc_pkg::XT_EN] <= hwdata[opmc_pkg::XT_EN];
            if (!lxt_is_sys)
                ls_ctrl_r[opmc_pkg::XT_MODE] <= hwdata[opmc_pkg::XT_MODE];
        end
    end

    // ------------------------------------------------------------
    // Stabilisation counters
    // ------------------------------------------------------------
    // Held at reload while disabled or its clock is stopped, so the flag drops first, then rises
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hs_cnt_r <= CNT_W_L'(HS_STABLE_CYC);
        else if (!hs_ctrl_r[opmc_pkg::XT_EN] || !hs_clk_run)
            hs_cnt_r <= CNT_W_L'(HS_STABLE_CYC);
        else if (hs_cnt_r != '0)
            hs_cnt_r <= hs_cnt_r - 1'b1;
    end

    // Speed-up picks the shorter start time
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ls_cnt_r <= CNT_W_L'(LS_SLOW_CYC);
        // Speed-up written together with the enable still gets the short count
        else if (!ls_ctrl_r[opmc_pkg::XT_EN] || !sub_clk_run
                 || (ls_ctrl_r[opmc_pkg::XT_MODE] && ls_cnt_r > CNT_W_L'(LS_FAST_CYC)))
            ls_cnt_r <= ls_ctrl_r[opmc_pkg::XT_MODE] ? CNT_W_L'(LS_FAST_CYC)
                                                     : CNT_W_L'(LS_SLOW_CYC);
        else if (ls_cnt_r != '0)
            ls_cnt_r <= ls_cnt_r - 1'b1;
    end

    // Internal slow RC is always running after power-on
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rc_cnt_r <= CNT_W_L'(RC_STABLE_CYC);
        else if (rc_cnt_r != '0)
            rc_cnt_r <= rc_cnt_r - 1'b1;
    end

    // ------------------------------------------------------------
    // Fast/slow switching
    // ------------------------------------------------------------
    logic want_sub;
    logic sub_ready;
    logic hs_ready;
    assign want_sub = (scc_r[7:opmc_pkg::SCC_SEL_LSB] == opmc_pkg::SEL_SLOW);
    assign sub_ready = scc_r[opmc_pkg::SCC_LF_SRC] ? ls_stable : rc_stable;
    assign hs_ready = scc_r[opmc_pkg::SCC_HF_SRC] ? hs_stable : 1'b1;

    // A dead cycle between sources keeps the output free of runts
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            on_sub_r <= 1'b0;
            div_r <= 3'h0;
            gap_r <= 1'b0;
        end
        else if (gap_r)
            gap_r <= 1'b0;
        else if (want_sub && !on_sub_r && sub_ready)
        begin
            on_sub_r <= 1'b1;
            gap_r <= 1'b1;
        end
        else if (!want_sub && (on_sub_r || div_r != scc_r[7:5]) && hs_ready)
        begin
            on_sub_r <= 1'b0;
            div_r <= scc_r[7:opmc_pkg::SCC_SEL_LSB];
            gap_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power-down modes
    // ------------------------------------------------------------
    logic halt_go;
    assign halt_go = halt_s2_r && (mode_r == opmc_pkg::OPMC_RUN);

    // Halt picks the mode only from the two idle enable bits
    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            opmc_pkg::OPMC_RUN:
                if (halt_s2_r)
                    case ({scc_r[opmc_pkg::SCC_HF_IDLE], scc_r[opmc_pkg::SCC_LF_IDLE]})
                        2'h0: mode_nxt = opmc_pkg::OPMC_SLEEP;
                        2'h1: mode_nxt = opmc_pkg::OPMC_IDLE_MODE_ZERO;
                        2'h3: mode_nxt = opmc_pkg::OPMC_IDLE_MODE_ONE;
                        default: mode_nxt = opmc_pkg::OPMC_IDLE_MODE_TWO;
                    endcase
            opmc_pkg::OPMC_SLEEP, opmc_pkg::OPMC_IDLE_MODE_ZERO,
            opmc_pkg::OPMC_IDLE_MODE_ONE, opmc_pkg::OPMC_IDLE_MODE_TWO:
                if (wake_s2_r)
                    mode_nxt = opmc_pkg::OPMC_RUN;
            default:
                mode_nxt = opmc_pkg::OPMC_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            mode_r <= opmc_pkg::OPMC_RUN;
        else
            mode_r <= mode_nxt;
    end

    // Set on entry wins over the clear instruction in the same cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pdf_r <= 1'b0;
            to_r <= 1'b0;
        end
        else if (halt_go)
        begin
            pdf_r <= 1'b1;
            to_r <= 1'b0;
        end
        else
        begin
            if (wdt_clear_instr)
                pdf_r <= 1'b0;
            if (wdt_timeout_evt)
                to_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Clock gating outputs
    // ------------------------------------------------------------
    logic in_run;
    logic run_nxt;
    logic hs_allowed;
    logic sub_allowed;
    logic sys_allowed;
    assign in_run = (mode_r == opmc_pkg::OPMC_RUN);
    // Gates follow the next mode so they move on the same edge as the mode
    assign run_nxt = (mode_nxt == opmc_pkg::OPMC_RUN);
    assign hs_allowed = run_nxt || mode_nxt == opmc_pkg::OPMC_IDLE_MODE_ONE
                        || mode_nxt == opmc_pkg::OPMC_IDLE_MODE_TWO;
    assign sub_allowed = run_nxt || mode_nxt == opmc_pkg::OPMC_IDLE_MODE_ZERO
                         || mode_nxt == opmc_pkg::OPMC_IDLE_MODE_ONE;
    // Idle modes keep the system clock for peripherals while its source runs
    assign sys_allowed = run_nxt || mode_nxt == opmc_pkg::OPMC_IDLE_MODE_ONE
                         || (mode_nxt == opmc_pkg::OPMC_IDLE_MODE_TWO && !on_sub_r)
                         || (mode_nxt == opmc_pkg::OPMC_IDLE_MODE_ZERO && on_sub_r);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hs_clk_run <= 1'b0;
            sub_clk_run <= 1'b0;
            sys_clk_run <= 1'b0;
            wdt_counter_clear <= 1'b0;
        end
        else
        begin
            hs_clk_run <= hs_allowed && hs_ctrl_r[opmc_pkg::XT_EN];
            sub_clk_run <= sub_allowed;
            sys_clk_run <= sys_allowed && !gap_r;
            wdt_counter_clear <= halt_go;
        end
    end

    assign hs_crystal_osc_en = hs_ctrl_r[opmc_pkg::XT_EN];
    assign hs_crystal_range_sel = hs_ctrl_r[opmc_pkg::XT_MODE];
    assign ls_crystal_osc_en = ls_ctrl_r[opmc_pkg::XT_EN];
    assign ls_crystal_speedup = ls_ctrl_r[opmc_pkg::XT_MODE];
    assign sys_on_sub = on_sub_r;
    assign sys_div_sel = div_r;
    assign cpu_hold = !in_run;
    assign wdt_run = wdt_enabled;
    assign power_down_flag = pdf_r;
    assign watchdog_timeout_flag = to_r;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (haddr)
            opmc_pkg::OFS_SYS_CLK_CTRL: rd_val[7:0] = scc_r;
            opmc_pkg::OFS_HS_XTAL_CTRL:
                rd_val[2:0] = {hs_ctrl_r[opmc_pkg::XT_MODE], hs_stable,
                               hs_ctrl_r[opmc_pkg::XT_EN]};
            opmc_pkg::OFS_LS_XTAL_CTRL:
                rd_val[2:0] = {ls_ctrl_r[opmc_pkg::XT_MODE], ls_stable,
                               ls_ctrl_r[opmc_pkg::XT_EN]};
            opmc_pkg::OFS_PWR_STATUS:
                rd_val[7:0] = {1'b0, mode_r, on_sub_r, gap_r, to_r, pdf_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read data registered for the data phase
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            hrdata <= 32'h0000_0000;
        else if (rd_now)
            hrdata <= rd_val;
    end

endmodule : opmc_top

`default_nettype wire

// ==== verilog/opmc_pkg.sv ====
// Purpose: Constants for the oscillator and power mode control block
// Assumes: AHB-Lite register access, 32-bit words, one register per word
// Notes: Offsets are chosen for this block; control bits sit in the low byte
//
// Function
// - Range bit picks crystal drive: 0 for up to 10 MHz, 1 above.
// - Range bit is locked while crystal pins are selected and crystal enabled.
// - Enabling the high-speed crystal clears its stable flag, then sets it when stable.
// - High-speed control bit 0 enables the crystal, reset value 0.
// - Speed-up bit 1 gives fast high-power start, 0 gives slow low-power start.
// - Speed-up bit is frozen while the low-speed crystal clocks the system.
// - Enabling the low-speed crystal clears its stable flag, then sets it when stable.
// - Low-speed control bit 0 enables the crystal, reset value 0.
// - Bits 7 to 3 of both crystal registers read as zero.
// - Selector code 111 moves the system to slow operation on the subsystem clock.
// - Switch into slow operation completes only once the chosen slow source is stable.
// - Codes 000 to 110 return to high-speed clock divided by 1 to 64.
// - Return to full rate waits for the high-speed oscillator to be stable; the code waits for it only while SCC_HF_SRC is 1.
// - Halt picks sleep or idle mode only from the two idle enable bits.
// - Halt with both idle enables 0 enters sleep; system clock stops.
// - Halt with high 0, low 1 enters idle zero; high-speed clock stops.
// - Halt with both idle enables 1 enters idle one; both clocks run.
// - Halt with high 1, low 0 enters idle two; subsystem clock stops.
// - Entering any power-down mode sets power-down flag and clears timeout flag.
// - Entering power-down clears the watchdog counter; it runs only if enabled.
// - Memory, registers and port states hold during sleep and idle modes.
// - Selector occupies bits 7 to 5 of the system clock control register.
// - Low-frequency source select picks RC oscillator at 0, crystal at 1.

package opmc_pkg;
    // Byte offsets of the registers
    localparam logic [7:0] OFS_SYS_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFS_HS_XTAL_CTRL = 8'h04;
    localparam logic [7:0] OFS_LS_XTAL_CTRL = 8'h08;
    localparam logic [7:0] OFS_PWR_STATUS = 8'h0c;
    // System clock control fields
    localparam int SCC_SEL_LSB = 5;
    localparam int SCC_HF_SRC = 3;
    localparam int SCC_LF_SRC = 2;
    localparam int SCC_HF_IDLE = 1;
    localparam int SCC_LF_IDLE = 0;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    // Crystal control fields
    localparam int XT_MODE = 2;
    localparam int XT_FLAG = 1;
    localparam int XT_EN = 0;
    // Power status fields
    localparam int PS_PDF = 0;
    localparam int PS_TO = 1;
    localparam int PS_MODE_LSB = 4;
    // Reset values
    localparam logic [7:0] SCC_RESET = 8'h00;
    localparam logic [2:0] XT_RESET = 3'h0;
    // Stabilisation times and derived counts at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int HS_STABLE_US = 1000;
    localparam int LS_FAST_US = 100000;
    localparam int LS_SLOW_US = 1000000;
    localparam int HS_STABLE_CYC = HS_STABLE_US * CLK_MHZ;
    localparam int LS_FAST_CYC = LS_FAST_US * CLK_MHZ;
    localparam int LS_SLOW_CYC = LS_SLOW_US * CLK_MHZ;
    localparam int RC_STABLE_CYC = 16;
    localparam int CNT_W = 28;

    typedef enum logic [2:0] {
        OPMC_RUN,
        OPMC_SLEEP,
        OPMC_IDLE_MODE_ZERO,
        OPMC_IDLE_MODE_ONE,
        OPMC_IDLE_MODE_TWO
    } opmc_mode_e;
endpackage : opmc_pkg

// ==== verif/opmc_props.sv ====
// Purpose: Port-level checks for opmc_top
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every opmc_top instance
`timescale 1ns/1ps
`default_nettype none

// ----------
// Checker
// ----------
module opmc_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wdt_enabled,
    input wire logic wdt_run,
    input wire logic wdt_counter_clear,
    input wire logic power_down_flag,
    input wire logic watchdog_timeout_flag,
    input wire logic cpu_hold,
    input wire logic hs_clk_run,
    input wire logic sub_clk_run,
    input wire logic sys_clk_run,
    input wire logic sys_on_sub,
    input wire logic [2:0] sys_div_sel,
    input wire logic crystal_pins_sel,
    input wire logic hs_crystal_osc_en,
    input wire logic hs_crystal_range_sel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Power-down entry and the crystal range lock window
    sequence s_entry;
        $rose(cpu_hold);
    endsequence
    sequence s_locked;
        crystal_pins_sel[*5] ##0 hs_crystal_osc_en;
    endsequence

    a_wdt_run_follow: assert property (wdt_run == wdt_enabled)
        else $error("watchdog run does not follow enable");
    a_entry_flags: assert property (s_entry |-> power_down_flag && !watchdog_timeout_flag)
        else $error("power-down entry flags wrong");
    a_entry_wdt_clr: assert property (s_entry |-> ##[0:2] wdt_counter_clear)
        else $error("watchdog counter not cleared on entry");
    a_clr_one_cycle: assert property (wdt_counter_clear |=> !wdt_counter_clear)
        else $error("watchdog clear longer than one cycle");
    a_sleep_stops: assert property (cpu_hold && !hs_clk_run && !sub_clk_run |-> !sys_clk_run)
        else $error("system clock runs in sleep");
    a_idle_mode_one_runs: assert property (cpu_hold && hs_clk_run && sub_clk_run |-> sys_clk_run)
        else $error("system clock stopped with both clocks on");
    a_fast_div_range: assert property (!sys_on_sub |-> sys_div_sel != 3'h7)
        else $error("divide code out of range in fast mode");
    a_slow_on_sub: assert property ($rose(sys_on_sub) |-> sub_clk_run)
        else $error("slow mode entered without subsystem clock");
    a_range_locked: assert property (s_locked |=> $stable(hs_crystal_range_sel))
        else $error("range bit changed while locked");
endmodule : opmc_props

bind opmc_top opmc_props u_props (
    .clk(clk), .reset_n(reset_n), .wdt_enabled(wdt_enabled), .wdt_run(wdt_run),
    .wdt_counter_clear(wdt_counter_clear), .power_down_flag(power_down_flag),
    .watchdog_timeout_flag(watchdog_timeout_flag), .cpu_hold(cpu_hold),
    .hs_clk_run(hs_clk_run), .sub_clk_run(sub_clk_run), .sys_clk_run(sys_clk_run),
    .sys_on_sub(sys_on_sub), .sys_div_sel(sys_div_sel), .crystal_pins_sel(crystal_pins_sel),
    .hs_crystal_osc_en(hs_crystal_osc_en), .hs_crystal_range_sel(hs_crystal_range_sel)
);
`default_nettype wire

// ==== verif/test_opmc_top.sv ====
// Purpose: Self-checking bench for opmc_top
// Assumes: Start-up counts shortened to 20, 30, 60 and 4 cycles
// Notes: Zero-wait AHB-Lite master built from tasks
`timescale 1ns/1ps
`default_nettype none

// ----------
// Bench top
// ----------
module test_opmc_top;
    logic clk, reset_n, hsel, hwrite, halt_exec, wake_req, wdt_enabled;
    logic wdt_clear_instr, crystal_pins_sel, wdt_timeout_evt, hreadyout, hresp;
    logic wdt_counter_clear, wdt_run, power_down_flag, watchdog_timeout_flag;
    logic hs_crystal_osc_en, hs_crystal_range_sel, ls_crystal_osc_en, ls_crystal_speedup;
    logic hs_clk_run, sub_clk_run, sys_clk_run, sys_on_sub, cpu_hold;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, sys_div_sel;
    logic [31:0] hwdata, hrdata, rd;
    int err_count, n_tests;

    // Short counts keep the run brief
    opmc_top #(.HS_STABLE_CYC(20), .LS_FAST_CYC(30), .LS_SLOW_CYC(60),
        .RC_STABLE_CYC(4)) dut_u (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_exec(halt_exec),
        .wake_req(wake_req), .wdt_enabled(wdt_enabled), .wdt_clear_instr(wdt_clear_instr),
        .crystal_pins_sel(crystal_pins_sel), .wdt_counter_clear(wdt_counter_clear),
        .wdt_run(wdt_run), .power_down_flag(power_down_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag), .wdt_timeout_evt(wdt_timeout_evt),
        .hs_crystal_osc_en(hs_crystal_osc_en), .hs_crystal_range_sel(hs_crystal_range_sel),
        .ls_crystal_osc_en(ls_crystal_osc_en), .ls_crystal_speedup(ls_crystal_speedup),
        .hs_clk_run(hs_clk_run), .sub_clk_run(sub_clk_run), .sys_clk_run(sys_clk_run),
        .sys_on_sub(sys_on_sub), .sys_div_sel(sys_div_sel), .cpu_hold(cpu_hold)
    );

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish(input bit hung);
        if (hung)
            err_count++;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Next edge with ready high; bounded so a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
                tally_and_finish(1'b1);
            @(posedge clk);
        end
    endtask : wait_ready

    // One single word transfer; read data taken at the closing edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        #1;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, rd, exp);
        chk("hresp", hresp, 32'h0);
    endtask : rdc

    task automatic poll_bit(input logic [7:0] a, input int b);
        int n;
        n = 0;
        xfer(1'b0, a, 32'h0);
        while (rd[b] !== 1'b1)
        begin
            n++;
            if (n > 40)
                tally_and_finish(1'b1);
            xfer(1'b0, a, 32'h0);
        end
    endtask : poll_bit

    task automatic wait_sig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v)
        begin
            n++;
            if (n > 200)
                tally_and_finish(1'b1);
            @(posedge clk);
        end
        #1;
    endtask : wait_sig

    // Reset values and an unmapped word
    task automatic t_reset();
        rdc("scc reset", 8'h00, 32'h0);
        rdc("high_speed_crystal_control reset", 8'h04, 32'h0);
        rdc("low_speed_crystal_control reset", 8'h08, 32'h0);
        wr(8'h10, 8'hff);
        rdc("unmapped", 8'h10, 32'h0);
    endtask : t_reset

    // Crystal enable, stable flag and range lock
    task automatic t_hs();
        wr(8'h04, 8'hfd);
        chk("range out", hs_crystal_range_sel, 32'h1);
        rdc("high_speed_crystal_control start", 8'h04, 32'h5);
        poll_bit(8'h04, 1);
        @(posedge clk);
        crystal_pins_sel <= 1'b1;
        repeat (6) @(posedge clk);
        wr(8'h04, 8'h01);
        chk("range held", hs_crystal_range_sel, 32'h1);
        @(posedge clk);
        crystal_pins_sel <= 1'b0;
        repeat (6) @(posedge clk);
        wr(8'h04, 8'h01);
        chk("range free", hs_crystal_range_sel, 32'h0);
        wr(8'h04, 8'h00);
        rdc("high_speed_crystal_control off", 8'h04, 32'h0);
        chk("hs osc en", hs_crystal_osc_en, 32'h0);
    endtask : t_hs

    // Slow mode in and out, speed-up lock, divide codes
    task automatic t_ls();
        wr(8'h08, 8'h05);
        rdc("low_speed_crystal_control start", 8'h08, 32'h5);
        chk("ls osc en", ls_crystal_osc_en, 32'h1);
        chk("speedup out", ls_crystal_speedup, 32'h1);
        wr(8'h00, 8'he4);
        chk("not yet slow", sys_on_sub, 32'h0);
        wait_sig(sys_on_sub, 1'b1);
        rdc("low_speed_crystal_control stable", 8'h08, 32'h7);
        wr(8'h08, 8'h01);
        rdc("speedup held", 8'h08, 32'h7);
        wr(8'h04, 8'h01);
        wr(8'h00, 8'hcc);
        chk("wait hs", sys_on_sub, 32'h1);
        wait_sig(sys_on_sub, 1'b0);
        rdc("hs ready", 8'h04, 32'h3);
        for (int i = 0; i < 7; i++)
        begin
            wr(8'h00, {i[2:0], 5'h08});
            repeat (20) if (sys_div_sel !== i[2:0]) @(posedge clk);
            chk("div code", sys_div_sel, i);
        end
    endtask : t_ls

    // Every halt mode: flags, clocks, watchdog clear, held registers
    task automatic t_halt();
        int clr;
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h00, {6'h0, i[1:0]});
            @(posedge clk);
            wdt_enabled <= i[0] ^ i[1];
            wdt_timeout_evt <= 1'b1;
            @(posedge clk);
            wdt_timeout_evt <= 1'b0;
            halt_exec <= 1'b1;
            @(posedge clk);
            halt_exec <= 1'b0;
            #1;
            chk("timeout set", watchdog_timeout_flag, 32'h1);
            clr = 0;
            repeat (8)
            begin
                @(posedge clk);
                #1;
                clr += int'(wdt_counter_clear === 1'b1);
            end
            chk("timeout flag", watchdog_timeout_flag, 32'h0);
            chk("pd flag", power_down_flag, 32'h1);
            chk("hold", cpu_hold, 32'h1);
            chk("hs clk", hs_clk_run, i[1]);
            chk("sub clk", sub_clk_run, i[0]);
            chk("sys clk", sys_clk_run, i[1]);
            chk("wdt clear", clr, 32'h1);
            rdc("scc kept", 8'h00, {6'h0, i[1:0]});
            @(posedge clk);
            wake_req <= 1'b1;
            @(posedge clk);
            wake_req <= 1'b0;
            wait_sig(cpu_hold, 1'b0);
            @(posedge clk);
            wdt_clear_instr <= 1'b1;
            @(posedge clk);
            wdt_clear_instr <= 1'b0;
            #1;
            chk("pd cleared", power_down_flag, 32'h0);
        end
    endtask : t_halt

    // Reset for ten cycles, then the scenarios
    initial
    begin
        {hsel, hwrite, halt_exec, wake_req, wdt_enabled, wdt_clear_instr} = '0;
        {crystal_pins_sel, wdt_timeout_evt, reset_n} = '0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h0;
        hwdata = 32'h0;
        err_count = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_hs();
        t_ls();
        t_halt();
        tally_and_finish(1'b0);
    end
endmodule : test_opmc_top
`default_nettype wire
